//--- rtl/rer_pkg.sv
// Package for the radio event router: register map, field layout,
// selector codes, radio state codes and the carrier structs.
// Assumes a 32-bit AHB-Lite bus and one 100 MHz clock domain.
package rer_pkg;

   // ------------------------------------------------------------
   // Register byte offsets.
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_A   = 8'h00;  // Output A control.
   localparam logic [7:0] OFS_CTRL_B   = 8'h04;  // Output B control.
   localparam logic [7:0] OFS_DATAPATH = 8'h08;  // Data path setup.
   localparam logic [7:0] OFS_RXTIMER  = 8'h0C;  // Receive window.
   localparam logic [7:0] OFS_FLAGS    = 8'h10;  // Latched flags, W1C.
   localparam logic [7:0] OFS_SOURCES  = 8'h14;  // Live source vector.

   // ------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------
   localparam int SEL_LSB   = 0;   // Five-bit source selector.
   localparam int EN_BIT    = 5;   // Output enable.
   localparam int POL_BIT   = 7;   // Polarity, in control A only.
   localparam int MODE_LSB  = 0;   // Data mode, two bits.
   localparam int DINEN_BIT = 2;   // Direct transmit input enable.
   localparam int DINSL_BIT = 3;   // Transmit input pin select.
   localparam int DOUT_LSB  = 4;   // Demodulated output pin, two bits.
   localparam int PIN3_LSB  = 6;   // Third pin function, two bits.
   localparam int FMT_LSB   = 8;   // Packet length format, two bits.
   localparam int WIN_LSB   = 0;   // First window length, 16 bits.
   localparam int EXT_LSB   = 16;  // Extension mode, four bits.
   localparam int TMREN_BIT = 20;  // Receive timer enable.

   // Reset values.
   localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
   localparam logic [31:0] RST_DATAPATH = 32'h0000_0000;
   localparam logic [31:0] RST_RXTIMER  = 32'h0000_0100;

   // ------------------------------------------------------------
   // Selector codes of note and mode values.
   // ------------------------------------------------------------
   localparam int          NUM_SRC   = 26;
   localparam logic [1:0]  MODE_DIR  = 2'h0;  // Direct mode.
   localparam logic [3:0]  EXT_NONE  = 4'h0;  // No window extension.
   localparam logic [3:0]  EXT_HOLD  = 4'h4;  // Stay while signal valid.
   localparam logic [1:0]  P3_CLOCK_OUTPUT   = 2'h0;  // Third pin: clock output.
   localparam logic [1:0]  P3_DATA   = 2'h1;  // Third pin: direct data.
   localparam logic [1:0]  P3_EVTB   = 2'h2;  // Third pin: output B.

   // Radio operating state codes.
   localparam logic [3:0] ST_STBY = 4'h2;
   localparam logic [3:0] ST_RFS  = 4'h3;
   localparam logic [3:0] ST_TFS  = 4'h4;
   localparam logic [3:0] ST_RX   = 4'h5;
   localparam logic [3:0] ST_TX   = 4'h6;

   // One-cycle event strobes from the radio and packet logic.
   typedef struct packed {
      logic preamble_found;
      logic sync_found;
      logic node_match;
      logic checksum_ok;
      logic packet_received;
      logic sleep_timeout;
      logic receive_timeout;
      logic transmit_done;
      logic line_code_err;
      logic node_err;
      logic collision;
      logic rxbuf_byte_written;
   } rer_evt_s;

   // Buffer condition levels.
   typedef struct packed {
      logic rxbuf_not_empty;
      logic rxbuf_over_threshold;
      logic rxbuf_full;
      logic rxbuf_overflow;
      logic txbuf_not_empty;
      logic txbuf_over_threshold;
      logic txbuf_full;
   } rer_buf_s;

   // Receive window states, Gray coded along idle, first, hold.
   typedef enum logic [1:0] {
      WIN_IDLE  = 2'b00,
      WIN_FIRST = 2'b01,
      WIN_HOLD  = 2'b11
   } rer_win_e;

endpackage

//--- rtl/rer_router.sv
// Radio event router: two selectable event outputs, direct and
// packet data routing, pin functions and the receive window timer.
// Assumes one clock, AHB-Lite registers and same-clock radio inputs;
// only the three pins cross in from outside and are synchronised.
//
// Operation
// - Both outputs share one source map.
// - Receive activity: tuning toward receive or receive.
// - Transmit activity: tuning toward transmit or transmit.
// - Signal valid follows detector, no clearing.
// - Preamble through packet-received latched until cleared.
// - Sleep, receive timeouts, transmit done latched.
// - Receive buffer levels tracked automatically.
// - Byte written gives one pulse per byte.
// - Transmit buffer levels tracked automatically.
// - Standby, synthesis, receive, transmit state indicators.
// - Low battery follows the supply comparator.
// - Radio activity: tuning, transmit or receive.
// - Packet finished latched on four causes.
// - Decoder reset on code, node error only.
// - Polarity one makes outputs active low.
// - Third pin: clock, data, output B, data clock.
// - Data mode zero routes demodulated bits to pin.
// - Direct transmit input from first or second pin.
// - Packet mode feeds packet handler, three length formats.
// - Extension mode zero exits when first window ends.
// - Extension mode four holds while signal valid.
`timescale 1ns/100ps

module rer_router
   import rer_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        CE,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic [3:0]  RADIO_STATE,
   input  wire logic        SIGNAL_VALID,
   input  wire logic        LOW_BATTERY,
   input  wire rer_evt_s    EVENTS,
   input  wire rer_buf_s    BUFFERS,
   input  wire logic        DEMOD_BIT,
   input  wire logic        DATA_STROBE,
   input  wire logic [2:0]  PIN_IN,
   output logic      [2:0]  PIN_OUT,
   output logic      [2:0]  PIN_OE,
   output logic             EVENT_OUT_A,
   output logic             EVENT_OUT_B,
   output logic             DECODER_RESET,
   output logic             TX_BIT,
   output logic             PKT_BIT,
   output logic             PKT_BIT_VALID,
   output logic      [1:0]  PKT_FORMAT,
   output logic             RX_EXIT
);

   // ------------------------------------------------------------
   // Bus slave.
   // ------------------------------------------------------------
   logic [31:0] ctrl_a_q;            // Output A selector and polarity.
   logic [31:0] ctrl_b_q;            // Output B selector.
   logic [31:0] path_q;              // Data path setup.
   logic [31:0] tmr_q;               // Receive window setup.
   logic [8:0]  flags_q;             // Latched events.
   logic [31:0] src;                 // Live source vector.
   logic        wr_pend_q;           // Write data phase pending.
   logic [7:0]  wr_addr_q;           // Address of pending write.
   logic        addr_ph;             // Valid address phase.

   // Pick one source by its selector code; codes beyond the map read 0.
   function automatic logic pick(input logic [4:0] s,
                                 input logic [31:0] v);
      pick = v[s];
   endfunction

   // Register value seen by a read at the given offset.
   function automatic logic [31:0] rd_val(input logic [7:0] a,
      input logic [31:0] ca, input logic [31:0] cb,
      input logic [31:0] pa, input logic [31:0] tm,
      input logic [8:0] fl, input logic [31:0] sv);
      case (a)
         OFS_CTRL_A:   rd_val = ca;
         OFS_CTRL_B:   rd_val = cb;
         OFS_DATAPATH: rd_val = pa;
         OFS_RXTIMER:  rd_val = tm;
         OFS_FLAGS:    rd_val = {23'h0, fl};
         OFS_SOURCES:  rd_val = sv;
         default:      rd_val = 32'h0;
      endcase
   endfunction

   assign addr_ph   = HSEL & HTRANS[1] & HREADY;
   assign HREADYOUT = 1'b1;          // Zero wait states, never stalls.
   assign HRESP     = 1'b0;          // Always OKAY.

   // Capture write address; data arrives in the next cycle.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (CE) begin
         wr_pend_q <= addr_ph & HWRITE;
         wr_addr_q <= HADDR[7:0];
      end
   end

   // Read data is registered at the address phase so it stands in
   // the data phase. A read right after a write to the same register
   // sees the old value; software should not rely on that ordering.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         HRDATA <= 32'h0;
      end else if (CE && addr_ph && !HWRITE) begin
         HRDATA <= rd_val(HADDR[7:0], ctrl_a_q, ctrl_b_q, path_q,
                          tmr_q, flags_q, src);
      end
   end

   // Configuration registers, written in the data phase.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_a_q <= RST_CTRL;
         ctrl_b_q <= RST_CTRL;
         path_q   <= RST_DATAPATH;
         tmr_q    <= RST_RXTIMER;
      end else if (CE && wr_pend_q) begin
         case (wr_addr_q)
            OFS_CTRL_A:   ctrl_a_q <= {24'h0, HWDATA[7:0]};
            OFS_CTRL_B:   ctrl_b_q <= {26'h0, HWDATA[5:0]};
            OFS_DATAPATH: path_q   <= {22'h0, HWDATA[9:0]};
            OFS_RXTIMER:  tmr_q    <= {11'h0, HWDATA[20:0]};
            default: ;               // Other offsets store nothing.
         endcase
      end
   end

   // ------------------------------------------------------------
   // Event flags and the source map.
   // ------------------------------------------------------------
   logic [8:0] flag_set;             // Events arriving this cycle.
   logic [8:0] flag_clr;             // Write-one-to-clear mask.
   logic       rx_act;               // Tuning toward or in receive.
   logic       tx_act;               // Tuning toward or in transmit.

   assign flag_set = {
      EVENTS.line_code_err | EVENTS.node_err | EVENTS.collision
         | EVENTS.packet_received,
      EVENTS.transmit_done, EVENTS.receive_timeout,
      EVENTS.sleep_timeout,
      EVENTS.packet_received, EVENTS.checksum_ok,
      EVENTS.node_match, EVENTS.sync_found,
      EVENTS.preamble_found};
   assign flag_clr = (wr_pend_q && wr_addr_q == OFS_FLAGS)
                     ? HWDATA[8:0] : 9'h0;

   // Flags hold until software clears; a new event beats the clear.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         flags_q <= 9'h0;
      end else if (CE) begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   assign rx_act = (RADIO_STATE == ST_RFS) | (RADIO_STATE == ST_RX);
   assign tx_act = (RADIO_STATE == ST_TFS) | (RADIO_STATE == ST_TX);

   // Source vector indexed by selector code.
   always_comb begin
      src       = 32'h0;
      src[0]    = rx_act;
      src[1]    = tx_act;
      src[2]    = SIGNAL_VALID;
      src[7:3]  = flags_q[4:0];
      src[10:8] = flags_q[7:5];
      src[11]   = BUFFERS.rxbuf_not_empty;
      src[12]   = BUFFERS.rxbuf_over_threshold;
      src[13]   = BUFFERS.rxbuf_full;
      src[14]   = EVENTS.rxbuf_byte_written;
      src[15]   = BUFFERS.rxbuf_overflow;
      src[16]   = BUFFERS.txbuf_not_empty;
      src[17]   = BUFFERS.txbuf_over_threshold;
      src[18]   = BUFFERS.txbuf_full;
      src[19]   = RADIO_STATE == ST_STBY;
      src[20]   = (RADIO_STATE == ST_RFS)
                  | (RADIO_STATE == ST_TFS);
      src[21]   = RADIO_STATE == ST_RX;
      src[22]   = RADIO_STATE == ST_TX;
      src[23]   = LOW_BATTERY;
      src[24]   = rx_act | tx_act;
      src[25]   = flags_q[8];
   end

   // Decoder restarts itself on code or node errors; a collision
   // leaves it waiting for the host.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         DECODER_RESET <= 1'b0;
      end else if (CE) begin
         DECODER_RESET <= EVENTS.line_code_err
                          | EVENTS.node_err;
      end
   end

   // ------------------------------------------------------------
   // Event outputs.
   // ------------------------------------------------------------
   logic pol;                        // One means active low.

   assign pol = ctrl_a_q[POL_BIT];

   // Both outputs use the same map; polarity is global. A disabled
   // output sits at its inactive level.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         EVENT_OUT_A <= 1'b0;
         EVENT_OUT_B <= 1'b0;
      end else if (CE) begin
         EVENT_OUT_A <= pol ^ (ctrl_a_q[EN_BIT]
                        & pick(ctrl_a_q[4:0], src));
         EVENT_OUT_B <= pol ^ (ctrl_b_q[EN_BIT]
                        & pick(ctrl_b_q[4:0], src));
      end
   end

   // ------------------------------------------------------------
   // Data path and pins.
   // ------------------------------------------------------------
   logic [2:0] pin_m_q;              // Synchroniser first stage.
   logic [2:0] pin_s_q;              // Synchroniser second stage.
   logic       direct;               // Direct mode selected.
   logic       clk_div_q;            // Clock output, half rate.
   logic [1:0] dout_pin;             // Pin carrying demodulated data.
   logic [1:0] p3fn;                 // Third pin function.

   assign direct   = path_q[1:0] == MODE_DIR;
   assign dout_pin = path_q[DOUT_LSB+:2];
   assign p3fn     = path_q[PIN3_LSB+:2];

   // Pin inputs pass two flops; only the second stage is read.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pin_m_q <= 3'h0;
         pin_s_q <= 3'h0;
      end else if (CE) begin
         pin_m_q <= PIN_IN;
         pin_s_q <= pin_m_q;
      end
   end

   // Clock output divider for the third pin.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         clk_div_q <= 1'b0;
      end else if (CE) begin
         clk_div_q <= ~clk_div_q;
      end
   end

   // Transmit bit from the chosen pin in direct mode, sent at once;
   // the host paces it near the data rate.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         TX_BIT <= 1'b0;
      end else if (CE) begin
         TX_BIT <= path_q[DINEN_BIT] & direct
                   & pin_s_q[path_q[DINSL_BIT]];
      end
   end

   // Packet mode hands demodulated bits to the packet handler.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         PKT_BIT       <= 1'b0;
         PKT_BIT_VALID <= 1'b0;
         PKT_FORMAT    <= 2'h0;
      end else if (CE) begin
         PKT_BIT       <= DEMOD_BIT;
         PKT_BIT_VALID <= ~direct & DATA_STROBE;
         PKT_FORMAT    <= path_q[FMT_LSB+:2];
      end
   end

   // Pin drivers. Pins one and two carry the event outputs unless
   // used for direct data; the third pin takes one of four functions.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         PIN_OUT <= 3'h0;
         PIN_OE  <= 3'h0;
      end else if (CE) begin
         PIN_OUT[0] <= EVENT_OUT_A;
         PIN_OE[0]  <= 1'b1;
         PIN_OUT[1] <= EVENT_OUT_B;
         PIN_OE[1]  <= 1'b1;
         if (direct && dout_pin < 2'h2) begin
            PIN_OUT[dout_pin[0]] <= DEMOD_BIT;
         end
         if (path_q[DINEN_BIT]) begin
            PIN_OE[path_q[DINSL_BIT]] <= 1'b0;
         end
         case (p3fn)
            P3_CLOCK_OUTPUT: begin
               PIN_OUT[2] <= clk_div_q;
               PIN_OE[2]  <= 1'b1;
            end
            P3_DATA: begin
               PIN_OUT[2] <= DEMOD_BIT;
               PIN_OE[2]  <= direct && dout_pin == 2'h2;
            end
            P3_EVTB: begin
               PIN_OUT[2] <= EVENT_OUT_B;
               PIN_OE[2]  <= 1'b1;
            end
            default: begin
               PIN_OUT[2] <= DATA_STROBE;
               PIN_OE[2]  <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Receive window timer.
   // ------------------------------------------------------------
   rer_win_e    win_q;               // Window state.
   logic [15:0] win_cnt_q;           // Cycles left in the first window.
   logic [3:0]  ext;                 // Extension mode.
   logic        in_rx;               // Radio is in receive.

   assign ext   = tmr_q[EXT_LSB+:4];
   assign in_rx = RADIO_STATE == ST_RX;

   // Modes other than zero and four behave as mode zero here.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         win_q     <= WIN_IDLE;
         win_cnt_q <= 16'h0;
         RX_EXIT   <= 1'b0;
      end else if (CE) begin
         RX_EXIT <= 1'b0;
         case (win_q)
            WIN_IDLE: begin
               if (in_rx && tmr_q[TMREN_BIT]) begin
                  win_q     <= WIN_FIRST;
                  win_cnt_q <= tmr_q[WIN_LSB+:16];
               end
            end
            WIN_FIRST: begin
               if (!in_rx) begin
                  win_q <= WIN_IDLE;
               end else if (ext == EXT_HOLD && SIGNAL_VALID) begin
                  win_q <= WIN_HOLD;
               end else if (win_cnt_q <= 16'h1) begin
                  win_q   <= WIN_IDLE;
                  RX_EXIT <= 1'b1;
               end else begin
                  win_cnt_q <= win_cnt_q - 16'h1;
               end
            end
            WIN_HOLD: begin
               if (!in_rx) begin
                  win_q <= WIN_IDLE;
               end else if (!SIGNAL_VALID) begin
                  win_q   <= WIN_IDLE;
                  RX_EXIT <= 1'b1;
               end
            end
            default: win_q <= WIN_IDLE;
         endcase
      end
   end

endmodule // rer_router

//--- testbench/rer_router_chk.sv
// Checker for the radio event router, watching top-level ports only.
// Assumes CE is held high by the bench, so every edge is an enabled edge.
`timescale 1ns/100ps
module rer_router_chk
   import rer_pkg::*;
(
   input wire logic       CLK,
   input wire logic       RESET,
   input wire logic       HREADYOUT,
   input wire logic       HRESP,
   input wire rer_evt_s   EVENTS,
   input wire logic [3:0] RADIO_STATE,
   input wire logic [2:0] PIN_IN,
   input wire logic       DATA_STROBE,
   input wire logic       DECODER_RESET,
   input wire logic       TX_BIT,
   input wire logic       PKT_BIT_VALID,
   input wire logic       RX_EXIT
);
   // ----
   // All properties share one clock and the synchronous reset.
   // ----
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   AST_READY_HIGH: assert property (HREADYOUT)
      else $error("slave inserted a wait state");
   AST_RESP_OKAY: assert property (!HRESP)
      else $error("slave answered with an error");
   AST_DEC_RST_CAUSE: assert property ((EVENTS.line_code_err || EVENTS.node_err)
      |=> DECODER_RESET)
      else $error("decoder not reset after a decode error");
   AST_DEC_RST_ONLY: assert property (DECODER_RESET
      |-> $past(EVENTS.line_code_err || EVENTS.node_err))
      else $error("decoder reset without a decode error");
   AST_RX_EXIT_PULSE: assert property (RX_EXIT |=> !RX_EXIT)
      else $error("receive exit longer than one cycle");
   AST_RX_EXIT_IN_RX: assert property (RX_EXIT |-> $past(RADIO_STATE) == ST_RX)
      else $error("receive exit outside receive state");
   AST_PKT_VALID: assert property (PKT_BIT_VALID |-> $past(DATA_STROBE))
      else $error("packet bit valid without data strobe");
   AST_TX_BIT_SRC: assert property (TX_BIT |-> (|$past(PIN_IN[1:0], 3)))
      else $error("transmit bit high without a high input pin");

   // Main scenarios reached.
   COV_DEC: cover property (DECODER_RESET);
   COV_EXIT: cover property (RX_EXIT);
   COV_TX: cover property ($rose(TX_BIT));
endmodule // rer_router_chk

bind rer_router rer_router_chk chk_u (.CLK(CLK), .RESET(RESET), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .EVENTS(EVENTS), .RADIO_STATE(RADIO_STATE), .PIN_IN(PIN_IN),
   .DATA_STROBE(DATA_STROBE), .DECODER_RESET(DECODER_RESET), .TX_BIT(TX_BIT),
   .PKT_BIT_VALID(PKT_BIT_VALID), .RX_EXIT(RX_EXIT));

//--- testbench/rer_host_model.sv
// Host model: sends eight direct-mode bits on the first or second pin.
// Assumes PERIOD matches the configured bit time, well inside tolerance.
`timescale 1ns/100ps
module rer_host_model #(
   parameter int PERIOD = 8
) (
   input wire logic       CLK,
   input wire logic       RESET,
   input wire logic       GO,
   input wire logic       SEL,
   input wire logic [7:0] BITS,
   output logic     [2:0] PINS
);
   logic       busy_q;  // Frame in progress.
   logic [2:0] idx_q;   // Bit index, MSB first.
   logic [7:0] cnt_q;   // Cycles within the bit.
   logic       idle_q;  // Toggling pattern on released pins.

   // Bit timing is held exactly at the nominal rate.
   always_ff @(posedge CLK) begin
      idle_q <= ~idle_q;
      if (RESET) begin
         busy_q <= 1'b0;
         idx_q  <= 3'h0;
         cnt_q  <= 8'h00;
         idle_q <= 1'b0;
      end else if (GO && !busy_q) begin
         busy_q <= 1'b1;
         idx_q  <= 3'h0;
         cnt_q  <= 8'h00;
      end else if (busy_q && cnt_q == 8'(PERIOD - 1)) begin
         cnt_q  <= 8'h00;
         idx_q  <= idx_q + 3'h1;
         busy_q <= (idx_q != 3'h7);
      end else if (busy_q) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Released pins show a changing pattern, never a held last value.
   always_comb begin
      PINS = {3{idle_q}};
      if (busy_q) begin
         PINS[SEL] = BITS[3'h7 - idx_q];
      end
   end
endmodule // rer_host_model

//--- testbench/test_rer_router.sv
// Self-checking bench for the radio event router over AHB-Lite.
// Assumes the package offsets and a zero-wait slave; CE held high.
`timescale 1ns/100ps
module test_rer_router
   import rer_pkg::*;
;
   logic clk = 0, rst = 1, hw = 0, sv = 0, lb = 0, dm = 0, ds = 0, go = 0, hsel_tx = 0;
   logic [31:0] ha = 0, wd = 0, rdat, rd;
   logic [1:0]  ht = 0;
   logic [3:0]  st = 0;
   logic [7:0]  pat = 8'hB4;
   rer_evt_s    ev = '0;
   rer_buf_s    bf = '0;
   logic [2:0]  pin, pout, poe;
   logic        rdy, resp, oa, ob, dres, txb, pb, pbv, rxe;
   logic [1:0]  pf;
   int          error_cnt = 0, checks = 0, n, k;

   always #5 clk = ~clk;

   rer_router dut_u (.CLK(clk), .RESET(rst), .CE(1'b1), .HSEL(1'b1), .HADDR(ha), .HTRANS(ht),
      .HWRITE(hw), .HSIZE(3'h2), .HWDATA(wd), .HREADY(rdy), .HRDATA(rdat), .HREADYOUT(rdy),
      .HRESP(resp), .RADIO_STATE(st), .SIGNAL_VALID(sv), .LOW_BATTERY(lb), .EVENTS(ev),
      .BUFFERS(bf), .DEMOD_BIT(dm), .DATA_STROBE(ds), .PIN_IN(pin), .PIN_OUT(pout),
      .PIN_OE(poe), .EVENT_OUT_A(oa), .EVENT_OUT_B(ob), .DECODER_RESET(dres), .TX_BIT(txb),
      .PKT_BIT(pb), .PKT_BIT_VALID(pbv), .PKT_FORMAT(pf), .RX_EXIT(rxe));
   rer_host_model host_u (.CLK(clk), .RESET(rst), .GO(go), .SEL(hsel_tx), .BITS(pat),
      .PINS(pin));

   // ----
   // Bus cycles and comparison.
   // ----
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      ht <= 2'h2; ha <= {24'h0, a}; hw <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      ht <= 2'h0; wd <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = rdat;
   endtask
   task automatic cyc(input int c); repeat (c) @(posedge clk); endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic t_regs();
      bus(0, OFS_CTRL_A, 0); chk(rd, RST_CTRL);
      bus(0, OFS_RXTIMER, 0); chk(rd, RST_RXTIMER);
      bus(1, 8'h20, 32'hFFFF_FFFF); bus(0, 8'h20, 0); chk(rd, 32'h0); // Unmapped place.
      $display("regs done");
   endtask
   task automatic t_states();
      logic [31:0] e;
      for (int i = 0; i < 8; i++) begin
         st <= 4'(i); sv <= i[0]; lb <= i[1]; cyc(2);
         bus(0, OFS_SOURCES, 0);
         e = '0; e[0] = (i == 3 || i == 5); e[1] = (i == 4 || i == 6); e[2] = i[0];
         e[19] = (i == 2); e[20] = (i == 3 || i == 4); e[21] = (i == 5); e[22] = (i == 6);
         e[23] = i[1]; e[24] = e[0] | e[1];
         chk(rd, e);
      end
      st <= 0; sv <= 0; lb <= 0; $display("states done");
   endtask
   task automatic t_flags();
      logic [31:0] e;
      for (int i = 0; i < 11; i++) begin
         ev <= rer_evt_s'(12'h800 >> i); cyc(1); ev <= '0;
         e = (i < 8) ? 32'h1 << i : 32'h100;
         if (i == 4) e[8] = 1'b1;
         bus(0, OFS_FLAGS, 0); chk(rd, e);
         bus(1, OFS_FLAGS, e); bus(0, OFS_FLAGS, 0); chk(rd, 32'h0);
      end
      bf <= '1; cyc(2); bus(0, OFS_SOURCES, 0);
      chk(rd & 32'h7F800, 32'h7B800);
      bf <= '0; bus(1, OFS_CTRL_A, 32'h2E); ev <= rer_evt_s'(12'h001); cyc(1); ev <= '0; n = 0;
      repeat (6) begin @(posedge clk); n += int'(oa === 1'b1); end
      chk(n, 1);
      $display("flags done");
   endtask
   task automatic t_outputs();
      sv <= 1; bus(1, OFS_CTRL_A, 32'h22); cyc(3); chk(oa, 1);
      bus(1, OFS_CTRL_B, 32'h22); cyc(3); chk(ob, 1);
      bus(1, OFS_CTRL_A, 32'hA2); cyc(3); chk({oa, ob}, 0);
      bus(1, OFS_CTRL_B, 32'h02); cyc(3); chk(ob, 1);
      bus(1, OFS_CTRL_A, 32'h9A); cyc(3); chk(oa, 1);
      bus(1, OFS_CTRL_A, 0); bus(1, OFS_CTRL_B, 0); sv <= 0; $display("outputs done");
   endtask
   task automatic t_data();
      for (int p = 0; p < 2; p++) begin
         bus(1, OFS_DATAPATH, 32'(p << 4)); dm <= 1; cyc(4); chk(pout[p], 1);
         dm <= 0; cyc(4); chk(pout[p], 0);
      end
      bus(1, OFS_DATAPATH, 32'hC); hsel_tx <= 1; cyc(2); chk(poe[1], 0);
      k = int'(pout[2]); cyc(1); chk({poe[2], pout[2]}, {1'b1, ~k[0]});
      go <= 1; cyc(1); go <= 0; cyc(7);
      for (k = 7; k >= 0; k--) begin chk(txb, pat[k]); cyc(8); end
      bus(1, OFS_DATAPATH, 32'h60); dm <= 1; cyc(3); chk({poe[2], pout[2]}, 2'h3);
      bus(1, OFS_DATAPATH, 32'hC0); ds <= 1; dm <= 0; cyc(3); chk({poe[2], pout[2]}, 2'h3);
      bus(1, OFS_DATAPATH, 32'h201); ds <= 1; dm <= 1; cyc(3);
      chk({pf, pbv, pb}, 4'hB);
      ds <= 0; dm <= 0; $display("data done");
   endtask
   task automatic t_window();
      bus(1, OFS_RXTIMER, 32'h10_0010); st <= ST_RX; n = 0;
      do begin @(posedge clk); n++; end while (rxe !== 1'b1 && n < 40);
      st <= ST_STBY; chk(n >= 16 && n <= 19, 1);
      bus(1, OFS_RXTIMER, 32'h14_0010); st <= ST_RX; cyc(4); sv <= 1; n = 0;
      repeat (30) begin @(posedge clk); n += int'(rxe === 1'b1); end
      chk(n, 0); sv <= 0; n = 0;
      do begin @(posedge clk); n++; end while (rxe !== 1'b1 && n < 6);
      st <= ST_STBY; chk(n <= 3, 1); $display("window done");
   endtask

   task automatic finish_test();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      cyc(16); rst <= 0; cyc(1);
      t_regs(); t_states(); t_flags(); t_outputs(); t_data(); t_window();
      finish_test();
   end
   initial begin
      cyc(20000); error_cnt++; finish_test();
   end
endmodule // test_rer_router
